// ### lfs_top.sv
/*
 * lfs_top: short, undervoltage and thermal supervision for the two
 * line drivers, with one lfs_channel per line.
 * Assumes measurement inputs are synchronous to sys_clk_i and that the
 * host pulses its strobes for one cycle.
 */
// How it works
// - filtered overcurrent switches off that line (both lines when paralleled)
// - protocol mode flags and interrupts at once
// - switching mode retries, then flags, restart timer
// - restart expiry re-drives; cycle repeats forever
// - 3-bit threshold ladder, doubled when paralleled
// - paralleled mode ignores aux threshold and enables
// - supply below selected level sets undervoltage flag
// - undervoltage interrupt when flag differs from reported
// - select code picks 15.0 V down to 6.0 V
// - overtemp flag is filtered comparator output
// - 5-bit setpoint selects trip threshold
// - thermal trip disables outputs, flags, interrupts
// - automatic release lowers threshold by hysteresis
// - die temperature readable as 7-bit Celsius
`timescale 1ns/1ps

module lfs_channel
    import lfs_pkg::*;
#(
    parameter int unsigned RETRY_CYC   = 20000,
    parameter int unsigned RESTART_CYC = 200000
) (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       enable_i,
    input  wire logic [9:0] current_i,
    input  wire logic [9:0] thresh_i,
    input  wire logic       no_retry_i,
    input  wire logic       host_restart_i,
    output logic            drive_o,
    output logic            event_o
);
    typedef enum logic [1:0] {CH_DRIVE, CH_RETRY, CH_RESTART} lfs_ch_t;
    lfs_ch_t          state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [1:0]       tries_reg;
    logic [CNT_W-1:0] calm_reg;
    logic             over;
    logic             trip;
    logic             last_try;

    assign over     = enable_i && (current_i > thresh_i);
    assign trip     = state_reg == CH_DRIVE && over
                   && cnt_reg == CNT_W'(SHORT_FILT_CYC);
    assign last_try = no_retry_i || tries_reg == 2'(RETRY_N);
    assign event_o  = trip && last_try;
    assign drive_o  = enable_i && state_reg == CH_DRIVE;

    // ------------------------------------------------------------
    // detect, retry, restart sequence
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= CH_DRIVE;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                CH_DRIVE: begin
                    // any dip below threshold restarts the filter
                    cnt_reg <= over ? cnt_reg + 1'b1 : '0;
                    if (trip) begin
                        cnt_reg   <= '0;
                        state_reg <= last_try ? CH_RESTART
                                              : CH_RETRY;
                    end
                end
                CH_RETRY: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(RETRY_CYC - 1)) begin
                        cnt_reg   <= '0;
                        state_reg <= CH_DRIVE;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (host_restart_i ||
                        cnt_reg == CNT_W'(RESTART_CYC - 1)) begin
                        cnt_reg   <= '0;
                        state_reg <= CH_DRIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tries_reg <= '0;
        end else if (trip && !last_try) begin
            tries_reg <= tries_reg + 1'b1;
        end else if (state_reg == CH_RESTART ||
                     calm_reg == CNT_W'(SHORT_FILT_CYC)) begin
            tries_reg <= '0;
        end
    end

    // a retry counts as a success only after a full quiet filter
    // window; the first cycles after a re-drive carry no current yet
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            calm_reg <= '0;
        end else if (state_reg != CH_DRIVE || over) begin
            calm_reg <= '0;
        end else if (calm_reg != CNT_W'(SHORT_FILT_CYC)) begin
            calm_reg <= calm_reg + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_short_off: assert property (trip |=> state_reg != CH_DRIVE)
        else $error("short did not switch the line off");
    a_proto_now: assert property (trip && no_retry_i |-> event_o)
        else $error("protocol short not flagged at once");
    a_retry_all: assert property (
        event_o |-> no_retry_i || tries_reg == 2'(RETRY_N))
        else $error("flag raised before all retries");
    a_retry_gap: assert property (
        state_reg == CH_RETRY && cnt_reg == CNT_W'(RETRY_CYC - 1)
        |=> state_reg == CH_DRIVE && cnt_reg == '0)
        else $error("retry delay not honoured");
    a_event_rst: assert property (event_o |=> state_reg == CH_RESTART)
        else $error("restart timer not started");
    a_restart: assert property (
        state_reg == CH_RESTART && cnt_reg == CNT_W'(RESTART_CYC - 1)
        |=> state_reg == CH_DRIVE)
        else $error("restart expiry did not re-drive");
    c_retry: cover property (trip && !last_try);
    c_restart: cover property (state_reg == CH_RESTART ##1
                               state_reg == CH_DRIVE);
endmodule : lfs_channel

module lfs_top
    import lfs_pkg::*;
#(
    parameter int unsigned RETRY_CYC   = RETRY_DELAY_US * 1000000
                                         / CLK_PERIOD_PS,
    parameter int unsigned RESTART_CYC = RESTART_US * 1000000
                                         / CLK_PERIOD_PS
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire lfs_cfg_t    cfg_i,
    input  wire logic        cq_drive_req_i,
    input  wire logic [9:0]  cq_current_ma_i,
    input  wire logic [9:0]  aux_current_ma_i,
    input  wire logic [7:0]  supply_dv_i,
    input  wire logic [6:0]  temp_code_i,
    input  wire logic        valid_msg_i,
    input  wire logic        host_reconfig_i,
    input  wire logic        short_flag_clear_i,
    input  wire logic        spi_exchange_i,
    output lfs_status_t      status_o,
    output logic             cq_drive_en_o,
    output logic             aux_hs_on_o,
    output logic             aux_ls_on_o,
    output logic             short_irq_o,
    output logic             uv_irq_o,
    output logic             ot_irq_o
);
    logic       join_m;
    logic       cq_drive;
    logic       aux_drive;
    logic       cq_event;
    logic       aux_event;
    logic       ot_trip_reg;
    logic       uv_reported_reg;
    logic       ot_raw;
    logic [3:0] ot_filt_reg;
    logic [6:0] trip_c;
    logic [6:0] active_c;
    logic [6:0] temp_c;
    logic [9:0] cq_sum;

    assign join_m = cfg_i.paralleled_output_mode;
    assign cq_sum = join_m ? cq_current_ma_i + aux_current_ma_i
                           : cq_current_ma_i;

    // ------------------------------------------------------------
    // line channels
    // ------------------------------------------------------------
    lfs_channel #(.RETRY_CYC(RETRY_CYC), .RESTART_CYC(RESTART_CYC)) u_cq (
        .sys_clk_i      (sys_clk_i),
        .sys_rst_i      (sys_rst_i),
        .enable_i       (cq_drive_req_i && !ot_trip_reg),
        .current_i      (cq_sum),
        .thresh_i       (lfs_short_ma(cfg_i.cq_short_threshold,
                                      join_m)),
        .no_retry_i     (!cfg_i.switching_io_mode),
        .host_restart_i (valid_msg_i || host_reconfig_i),
        .drive_o        (cq_drive),
        .event_o        (cq_event)
    );

    // joined, the aux high side follows the main line, the low side
    // stays off, and the aux stage's own settings are don't-care
    lfs_channel #(.RETRY_CYC(RETRY_CYC), .RESTART_CYC(RESTART_CYC)) u_aux (
        .sys_clk_i      (sys_clk_i),
        .sys_rst_i      (sys_rst_i),
        .enable_i       (!join_m && !ot_trip_reg &&
                         (cfg_i.dio_high_side_enable ||
                          cfg_i.dio_low_side_enable)),
        .current_i      (aux_current_ma_i),
        .thresh_i       (lfs_short_ma(cfg_i.dio_short_threshold,
                                      1'b0)),
        .no_retry_i     (!cfg_i.aux_independent_mode),
        .host_restart_i (valid_msg_i || host_reconfig_i),
        .drive_o        (aux_drive),
        .event_o        (aux_event)
    );

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cq_drive_en_o <= 1'b0;
            aux_hs_on_o   <= 1'b0;
            aux_ls_on_o   <= 1'b0;
        end else begin
            cq_drive_en_o <= cq_drive;
            aux_hs_on_o   <= join_m ? cq_drive
                           : aux_drive && cfg_i.dio_high_side_enable;
            aux_ls_on_o   <= join_m ? 1'b0
                           : aux_drive && cfg_i.dio_low_side_enable;
        end
    end

    // ------------------------------------------------------------
    // short flag: a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_o.short_circuit_flag <= 1'b0;
            short_irq_o                 <= 1'b0;
        end else begin
            short_irq_o <= cq_event || aux_event;
            if (cq_event || aux_event) begin
                status_o.short_circuit_flag <= 1'b1;
            end else if (short_flag_clear_i) begin
                status_o.short_circuit_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // undervoltage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_o.undervoltage_flag <= 1'b0;
            uv_reported_reg            <= 1'b0;
        end else begin
            status_o.undervoltage_flag <= supply_dv_i <
                UV_TABLE_DV[cfg_i.undervoltage_threshold_sel];
            if (spi_exchange_i) begin
                uv_reported_reg <= status_o.undervoltage_flag;
            end
        end
    end

    assign uv_irq_o = status_o.undervoltage_flag != uv_reported_reg;

    // ------------------------------------------------------------
    // temperature and thermal trip
    // ------------------------------------------------------------
    assign temp_c   = lfs_meas_c(temp_code_i);
    assign trip_c   = lfs_trip_c(cfg_i.thermal_setpoint);
    assign active_c = (ot_trip_reg && !cfg_i.thermal_release_select)
                    ? trip_c - HYST_C : trip_c;
    // automatic release needs the die strictly below the lowered level
    assign ot_raw   = (ot_trip_reg && !cfg_i.thermal_release_select)
                    ? temp_c >= active_c : temp_c > active_c;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_o.die_temperature_value <= '0;
        end else begin
            status_o.die_temperature_value <= temp_c;
        end
    end

    // flag moves only after the comparator holds a new level for
    // a full filter window, so sensor chatter never reaches it
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ot_filt_reg            <= '0;
            status_o.overtemp_flag <= 1'b0;
        end else if (ot_raw == status_o.overtemp_flag) begin
            ot_filt_reg <= '0;
        end else if (ot_filt_reg == 4'(TEMP_FILT_CYC - 1)) begin
            ot_filt_reg            <= '0;
            status_o.overtemp_flag <= ot_raw;
        end else begin
            ot_filt_reg <= ot_filt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ot_trip_reg <= 1'b0;
            ot_irq_o    <= 1'b0;
        end else begin
            ot_irq_o <= 1'b0;
            if (status_o.overtemp_flag && !ot_trip_reg) begin
                ot_trip_reg <= 1'b1;
                ot_irq_o    <= 1'b1;
            end else if (ot_trip_reg && !status_o.overtemp_flag &&
                         (!cfg_i.thermal_release_select ||
                          host_reconfig_i)) begin
                ot_trip_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_short_sticky: assert property (
        cq_event || aux_event |=> status_o.short_circuit_flag && short_irq_o)
        else $error("short event lost");
    a_uv_track: assert property (
        ##1 status_o.undervoltage_flag == $past(supply_dv_i <
            UV_TABLE_DV[cfg_i.undervoltage_threshold_sel]))
        else $error("undervoltage flag wrong");
    a_uv_report: assert property (
        spi_exchange_i ##1 $stable(status_o.undervoltage_flag) |-> !uv_irq_o)
        else $error("uv interrupt after matching report");
    a_ot_off: assert property (ot_trip_reg |=> !cq_drive_en_o
                               && !aux_hs_on_o && !aux_ls_on_o)
        else $error("outputs live during thermal trip");
    a_ot_hyst: assert property (
        ot_trip_reg && status_o.overtemp_flag
        && !cfg_i.thermal_release_select
        && temp_c >= 7'(trip_c - HYST_C)
        |=> status_o.overtemp_flag)
        else $error("released above the hysteresis level");
    a_ot_hold: assert property (
        ot_trip_reg && cfg_i.thermal_release_select && !host_reconfig_i
        |=> ot_trip_reg)
        else $error("manual release left trip early");
    c_ot_trip: cover property ($rose(ot_trip_reg) ##[1:1000] !ot_trip_reg);
    c_uv_irq: cover property ($rose(uv_irq_o));
endmodule : lfs_top

// ### lfs_pkg.sv
/*
 * lfs_pkg: constants, tables and carrier types for the line fault
 * supervisor. Assumes a 200 MHz system clock.
 */
package lfs_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    localparam int unsigned SHORT_FILTER_NS  = 10000;
    localparam int unsigned SHORT_FILT_CYC   =
        (SHORT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RETRY_DELAY_US   = 100;
    localparam int unsigned RESTART_US       = 1000;
    localparam int unsigned RETRY_N          = 3;
    localparam int unsigned TEMP_FILT_CYC    = 16;
    localparam int unsigned CNT_W            = 20;
    // ------------------------------------------------------------
    // short thresholds, mA: code xor 4 indexes an even ladder
    // ------------------------------------------------------------
    localparam logic [2:0] SHORT_CODE_FLIP   = 3'h4;
    localparam logic [9:0] SHORT_BASE_MA     = 10'h06E;
    localparam logic [9:0] SHORT_STEP_MA     = 10'h014;
    // ------------------------------------------------------------
    // undervoltage thresholds in tenths of a volt, by select code
    // ------------------------------------------------------------
    localparam logic [7:0] UV_TABLE_DV [8] = '{
        8'h96, 8'h8C, 8'h82, 8'h78, 8'h69, 8'h55, 8'h4B, 8'h3C};
    // ------------------------------------------------------------
    // thermal tables, degrees Celsius (plain defaults)
    // ------------------------------------------------------------
    localparam logic [6:0] TRIP_BASE_C       = 7'h3C;
    localparam logic [6:0] TRIP_STEP_C       = 7'h02;
    localparam logic [6:0] HYST_C            = 7'h0A;
    localparam logic [6:0] TEMP_OFFSET_C     = 7'h00;

    typedef struct packed {
        logic [2:0] cq_short_threshold;
        logic [2:0] dio_short_threshold;
        logic       dio_high_side_enable;
        logic       dio_low_side_enable;
        logic       paralleled_output_mode;
        logic       switching_io_mode;
        logic       aux_independent_mode;
        logic [2:0] undervoltage_threshold_sel;
        logic [4:0] thermal_setpoint;
        logic       thermal_release_select;
    } lfs_cfg_t;

    typedef struct packed {
        logic       short_circuit_flag;
        logic       undervoltage_flag;
        logic       overtemp_flag;
        logic [6:0] die_temperature_value;
    } lfs_status_t;

    function automatic logic [9:0] lfs_short_ma(input logic [2:0] code,
                                                input logic       dbl);
        logic [9:0] ma;
        ma = SHORT_BASE_MA
           + SHORT_STEP_MA * {7'h00, code ^ SHORT_CODE_FLIP};
        return dbl ? {ma[8:0], 1'b0} : ma;
    endfunction : lfs_short_ma

    function automatic logic [6:0] lfs_trip_c(input logic [4:0] code);
        return 7'(TRIP_BASE_C + TRIP_STEP_C * {2'h0, code});
    endfunction : lfs_trip_c

    function automatic logic [6:0] lfs_meas_c(input logic [6:0] code);
        return 7'(code + TEMP_OFFSET_C);
    endfunction : lfs_meas_c
endpackage : lfs_pkg

// ### lfs_line_load.sv
/*
 * lfs_line_load: behavioural load on one driven line, normal or shorted.
 * Assumes drive_i is the supervisor's registered driver enable.
 */
`timescale 1ns/1ps

module lfs_line_load (
    input  wire logic       drive_i,
    input  wire logic       short_i,
    input  wire logic [9:0] short_ma_i,
    input  wire logic [9:0] load_ma_i,
    output logic [9:0]      current_o
);
    // a switched-off driver sources nothing, shorted or not
    always_comb begin
        if (!drive_i) begin
            current_o = 10'h000;
        end else if (short_i) begin
            current_o = short_ma_i;
        end else begin
            current_o = load_ma_i;
        end
    end
endmodule : lfs_line_load

// ### lfs_top_tb.sv
/*
 * lfs_top_tb: self-checking bench for lfs_top with two line loads.
 * Assumes lfs_pkg, lfs_top and lfs_line_load are compiled first.
 */
`timescale 1ns/1ps

module lfs_top_tb
    import lfs_pkg::*;
;
    localparam int RTY = 20;
    localparam int RST = 50;
    localparam int F   = SHORT_FILT_CYC;

    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    lfs_cfg_t    cfg       = '0;
    logic        req       = 1'b0;
    logic        vmsg      = 1'b0;
    logic        rcfg      = 1'b0;
    logic        clr       = 1'b0;
    logic        spi       = 1'b0;
    logic        cq_sh     = 1'b0;
    logic        aux_sh    = 1'b0;
    logic [9:0]  s_ma      = 10'h000;
    logic [9:0]  ld_ma     = 10'h000;
    logic [7:0]  sup       = 8'hFF;
    logic [6:0]  tmp       = 7'h00;
    logic [31:0] seed      = 32'h5f67;
    logic [9:0]  cq_ma;
    logic [9:0]  aux_ma;
    lfs_status_t st;
    logic        cq_en;
    logic        hs;
    logic        ls;
    logic        s_irq;
    logic        u_irq;
    logic        o_irq;
    int          bad_count  = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    // reference figures, in volts times ten
    int          sup_tbl[$] = '{150, 140, 130, 120, 105, 85, 75, 60};

    lfs_top #(.RETRY_CYC(RTY), .RESTART_CYC(RST)) u_dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg),
        .cq_drive_req_i(req), .cq_current_ma_i(cq_ma),
        .aux_current_ma_i(aux_ma), .supply_dv_i(sup),
        .temp_code_i(tmp), .valid_msg_i(vmsg), .host_reconfig_i(rcfg),
        .short_flag_clear_i(clr), .spi_exchange_i(spi), .status_o(st),
        .cq_drive_en_o(cq_en), .aux_hs_on_o(hs), .aux_ls_on_o(ls),
        .short_irq_o(s_irq), .uv_irq_o(u_irq), .ot_irq_o(o_irq));

    lfs_line_load u_cq_load (.drive_i(cq_en), .short_i(cq_sh),
        .short_ma_i(s_ma), .load_ma_i(ld_ma), .current_o(cq_ma));
    // paralleled aux current would add to the cq sum, so none there
    lfs_line_load u_aux_load (.drive_i(hs | ls), .short_i(aux_sh),
        .short_ma_i(10'h12C),
        .load_ma_i(cfg.paralleled_output_mode ? 10'h000 : ld_ma),
        .current_o(aux_ma));

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // model, drivers and compares
    // ------------------------------------------------------------
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h7fff_ffff);
    endfunction : rnd

    function automatic int exp_ma(input int code, input bit par);
        int ma;
        ma = (code >= 4) ? 110 + 20 * (code - 4) : 190 + 20 * code;
        return par ? 2 * ma : ma;
    endfunction : exp_ma

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step

    task automatic chk_val(input string w, input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask : chk_val

    task automatic chk_bit(input string w, input logic g, e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask : chk_bit

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask : pulse

    task automatic wait_sig(ref logic s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (s !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_sig

    // counts driver switch-offs seen before the short event
    task automatic wait_short(input int lim, output int n, output int f);
        logic prev;
        n = 0;
        f = 0;
        prev = cq_en & hs;
        while (s_irq !== 1'b1 && n < lim) begin
            step(1);
            n++;
            if (prev === 1'b1 && (cq_en & hs) === 1'b0) f++;
            prev = cq_en & hs;
        end
    endtask : wait_short

    task automatic recover();
        cq_sh = 1'b0;
        aux_sh = 1'b0;
        pulse(clr);
        step(RST + 10);
        chk_bit("flag clear", st.short_circuit_flag, 1'b0);
    endtask : recover

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            $display("[FAIL] %0t timeout got %h exp %h", $time, cyc, 0);
            final_report();
        end
    end

    initial begin
        int n;
        int f;
        int thr;
        int code;
        ld_ma = 10'(rnd() % 100);
        step(10);
        chk_val("reset", 32'(st), 32'h0000_0000);
        sys_rst_i = 1'b0;
        cfg.cq_short_threshold = 3'h4;
        cfg.dio_high_side_enable = 1'b1;
        req = 1'b1;
        s_ma = 10'h12C;
        step(5);
        cq_sh = 1'b1;
        wait_short(F + 20, n, f);
        chk_bit("filter", n >= F && n <= F + 3, 1'b1);
        chk_val("no retry", f, 0);
        chk_bit("flag set", st.short_circuit_flag, 1'b1);
        step(2);
        chk_bit("cq off", cq_en, 1'b0);
        chk_bit("aux kept", hs, 1'b1);
        cq_sh = 1'b0;
        pulse(vmsg);
        wait_sig(cq_en, 1'b1, 5, n);
        chk_bit("msg redrive", cq_en, 1'b1);
        recover();
        cq_sh = 1'b1;
        wait_short(F / 2, n, f);
        cq_sh = 1'b0;
        step(2);
        cq_sh = 1'b1;
        wait_short(F - 20, n, f);
        chk_val("gap resets", n, F - 20);
        wait_short(100, n, f);
        chk_bit("late trip", n < 100, 1'b1);
        recover();
        aux_sh = 1'b1;
        wait_short(F + 20, n, f);
        step(2);
        chk_bit("aux off", hs, 1'b0);
        chk_bit("cq kept", cq_en, 1'b1);
        recover();
        $display("test short_line done");
        cfg.switching_io_mode = 1'b1;
        cfg.aux_independent_mode = 1'b1;
        for (int r = 0; r < 3; r++) begin
            cq_sh = (r < 2);
            aux_sh = (r == 2);
            wait_short(5 * F, n, f);
            chk_val("retries", f, RETRY_N);
            step(2);
            pulse(clr);
            if (r < 2) wait_sig(cq_en, 1'b1, RST + 10, n);
            else wait_sig(hs, 1'b1, RST + 10, n);
            chk_bit("restart", n >= RST - 5 && n < RST + 10, 1'b1);
        end
        cfg.switching_io_mode = 1'b0;
        cfg.aux_independent_mode = 1'b0;
        recover();
        $display("test retry done");
        for (int i = 0; i < 10; i++) begin
            code = (i < 8) ? i : i - 5;
            cfg.cq_short_threshold = 3'(code);
            cfg.paralleled_output_mode = (i >= 8);
            cfg.dio_short_threshold = 3'(7 - code);
            cfg.dio_low_side_enable = (i >= 8);
            thr = exp_ma(code, i >= 8);
            s_ma = 10'(thr);
            cq_sh = 1'b1;
            wait_short(F + 50, n, f);
            chk_val("at level", n, F + 50);
            s_ma = 10'(thr + 1);
            wait_short(F + 50, n, f);
            chk_bit("above", n < F + 50, 1'b1);
            if (i >= 8) chk_bit("low off", ls, 1'b0);
            recover();
        end
        cfg.paralleled_output_mode = 1'b0;
        cfg.dio_low_side_enable = 1'b0;
        $display("test thresholds done");
        for (int k = 0; k < 8; k++) begin
            cfg.undervoltage_threshold_sel = 3'(k);
            sup = 8'(sup_tbl[k] - 1);
            step(3);
            chk_bit("low supply", st.undervoltage_flag, 1'b1);
            chk_bit("irq up", u_irq, 1'b1);
            pulse(spi);
            chk_bit("irq ack", u_irq, 1'b0);
            sup = 8'(sup_tbl[k]);
            step(3);
            chk_bit("at level", st.undervoltage_flag, 1'b0);
            chk_bit("irq back", u_irq, 1'b1);
            pulse(spi);
        end
        $display("test supply done");
        for (int m = 0; m < 2; m++) begin
            code = rnd() % 32;
            cfg.thermal_setpoint = 5'(code);
            cfg.thermal_release_select = (m == 1);
            thr = 60 + 2 * code;
            tmp = 7'(thr + 1);
            step(8);
            tmp = 7'(thr - 20);
            step(30);
            chk_bit("hot blip", st.overtemp_flag, 1'b0);
            tmp = 7'(thr + 1);
            wait_sig(o_irq, 1'b1, 40, n);
            chk_bit("ot irq", o_irq, 1'b1);
            chk_bit("hot flag", st.overtemp_flag, 1'b1);
            step(2);
            chk_bit("hot off", cq_en | hs, 1'b0);
            tmp = 7'(thr - 10);
            step(40);
            chk_bit("held", st.overtemp_flag, m == 0);
            tmp = 7'(thr - 11);
            step(40);
            chk_bit("cooled", st.overtemp_flag, 1'b0);
            chk_bit("resumed", cq_en, m == 0);
            if (m == 1) pulse(rcfg);
            wait_sig(cq_en, 1'b1, 10, n);
            chk_bit("host release", cq_en, 1'b1);
            tmp = 7'(thr);
            step(40);
            chk_bit("level back", st.overtemp_flag, 1'b0);
        end
        cfg.thermal_setpoint = 5'h1F;
        for (int j = 0; j < 8; j++) begin
            tmp = 7'(rnd() % 120);
            step(3);
            chk_val("die", st.die_temperature_value, tmp);
        end
        $display("test thermal done");
        final_report();
    end
endmodule : lfs_top_tb
